/* flash_rd_defines.vh */
/*
 * Constants for the flash read-extension sequencer: opcodes, the
 * wrap-on nibble, boot register layout and delay/dummy counts.
 * Assumes inclusion by the sequencer module and the bench; the synchroniser and buffer do not use it.
 */
// Summary of operation
// - burst setting is C0h, then a nibble: 0h wrap on, 1h wrap off
// - depth code 00h..03h gives 8,16,32,64 byte wrap; 1xh disables wrap
// - wrap groups stay inside a 256-byte page, any start address allowed
// - wrap starts disabled; held until next C0h, power loss or reset
// - wrap applies to quad io read EBh in single-line and quad command mode
// - enhance mode only for EBh and ECh, never for dual io reads
// - indicator whose high nibble complements its low nibble keeps enhance
// - non-complementary indicator then chip select cycle leaves enhance
// - in enhance mode a new frame starts directly with address
// - indicator is followed by 4 dummy cycles by default, then data
// - dummy count for quad reads comes from configuration bits 6 and 7
// - in four-line transfers each nibble's msb is on io line 3
// - a reset during operation returns the device to single-line commands; here command width still follows quad_command_mode
// - with fast boot enabled a read starts by itself after any reset
// - boot data comes from start address after delay; host takes a byte
// - chip select rise ends boot output; normal commands follow
// - boot data on one line when quad enable is 0, four lines when 1
// - boot delay field 00,01,10,11 gives 7,9,11,13 cycles; default 13
// - boot register bit 0 is an active-low enable, default 1 (off)
// - boot register bits 31..4 give a 16-byte aligned start address
// - boot register changes only by its write/erase, read back by read; here nrst also restores its default
`ifndef FLASH_RD_DEFINES_VH
`define FLASH_RD_DEFINES_VH

`define OP_BURST_SET 8'hc0
`define OP_QUAD_READ 8'heb
`define OP_QUAD_READ_4B 8'hec
`define OP_BOOT_REG_WRITE 8'h16
`define OP_BOOT_REG_ERASE 8'h17
`define OP_BOOT_REG_READ 8'h18
`define OP_RESET_MODES 8'h99

`define BOOT_REG_RESET 32'hffffffff
`define BOOT_EN_N_BIT 0
`define BOOT_DLY_LSB 1
`define BOOT_ADDR_LSB 4

`define BOOT_DLY_00 5'd7
`define BOOT_DLY_01 5'd9
`define BOOT_DLY_10 5'd11
`define BOOT_DLY_11 5'd13

`define DUMMY_CFG_00 5'd4
`define DUMMY_CFG_01 5'd6
`define DUMMY_CFG_10 5'd8
`define DUMMY_CFG_11 5'd10

`define WRAP_ON_NIBBLE 4'h0

`endif

/* pin_sync.v */
/*
 * Two-flop synchroniser for a group of level inputs.
 * Assumes the inputs are unrelated to clk; only the second stage is read.
 */
`timescale 1ns/1ns
module pin_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
)(
  input wire clk,
  input wire nrst,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_q;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q <= INIT;
      q <= INIT;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

/* byte_buf2.v */
/*
 * Two-entry valid/ready buffer with a synchronous flush.
 * Assumes producer and consumer share clk.
 */
`timescale 1ns/1ns
module byte_buf2 #(
  parameter W = 8
)(
  input wire clk,
  input wire nrst,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_q [0:1];
  reg wp_q;
  reg rp_q;
  reg [1:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk)
  begin
    if (push)
      mem_q[wp_q] <= in_data;
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'd0;
    end
    else if (flush)
    begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'd0;
    end
    else
    begin
      if (push)
        wp_q <= ~wp_q;
      if (pop)
        rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

/* flash_rd_seq.v */
/*
 * Read-extension sequencer of a serial flash: burst wrap, enhance
 * (command-skipping) mode, fast boot and its boot register.
 * Assumes the host drives cs_n and sclk (sclk far slower than clk);
 * pins are sampled by clk. Mode bits come in as plain inputs.
 */
`timescale 1ns/1ns
`include "flash_rd_defines.vh"
module flash_rd_seq #(
  parameter AW = 10
)(
  input wire clk,
  input wire nrst,
  input wire rst_pin_n,
  input wire cs_n,
  input wire sclk,
  input wire [3:0] io_in,
  output reg [3:0] io_out_q,
  output reg [3:0] io_oe_q,
  input wire quad_enable_bit,
  input wire quad_command_mode,
  input wire addr4_mode,
  input wire dummy_cfg_low,
  input wire dummy_cfg_high,
  input wire mem_we,
  input wire [AW-1:0] mem_waddr,
  input wire [7:0] mem_wdata,
  output reg wrap_on_q,
  output reg enhance_q,
  output reg boot_armed_q
);
  localparam ST_IDLE = 4'd0;
  localparam ST_CMD = 4'd1;
  localparam ST_ADDR = 4'd2;
  localparam ST_MODE = 4'd3;
  localparam ST_DUMMY = 4'd4;
  localparam ST_DATA = 4'd5;
  localparam ST_WRAP = 4'd6;
  localparam ST_REGW = 4'd7;
  localparam ST_BOOT = 4'd8;
  localparam ST_SKIP = 4'd9;

  function [4:0] dummy_cycles;
    input [1:0] cfg;
    begin
      case (cfg)
        2'b00: dummy_cycles = `DUMMY_CFG_00;
        2'b01: dummy_cycles = `DUMMY_CFG_01;
        2'b10: dummy_cycles = `DUMMY_CFG_10;
        default: dummy_cycles = `DUMMY_CFG_11;
      endcase
    end
  endfunction

  function [4:0] boot_delay;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: boot_delay = `BOOT_DLY_00;
        2'b01: boot_delay = `BOOT_DLY_01;
        2'b10: boot_delay = `BOOT_DLY_10;
        default: boot_delay = `BOOT_DLY_11;
      endcase
    end
  endfunction

  wire [6:0] pins_s;
  reg sclk_d_q;
  reg cs_d_q;
  wire cs_s = pins_s[5];
  wire sclk_s = pins_s[4];
  wire [3:0] io_s = pins_s[3:0];
  wire rst_pin_s = pins_s[6];
  wire rise = sclk_s && !sclk_d_q && !cs_s;
  wire fall = !sclk_s && sclk_d_q && !cs_s;
  wire cs_fall = !cs_s && cs_d_q;
  wire cs_rise = cs_s && !cs_d_q;

  pin_sync #(.W(7), .INIT(7'h60)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({rst_pin_n, cs_n, sclk, io_in}),
    .q(pins_s)
  );

  reg [7:0] mem [0:(1<<AW)-1];
  reg [3:0] st_q;
  reg wide_q;
  reg [5:0] cnt_q;
  reg [31:0] sh_q;
  reg [7:0] cmd_q;
  reg alen32_q;
  reg [4:0] dly_q;
  reg [31:0] boot_reg_q;
  reg [1:0] wrap_depth_q;
  reg enh_pend_q;
  reg mode_seen_q;
  reg erase_pend_q;
  reg reset_pend_q;
  reg rd_reg_q;
  reg boot_frame_q;
  reg rearm_q;
  reg [31:0] faddr_q;
  reg [2:0] ocnt_q;
  reg [7:0] obyte_q;

  wire [5:0] nb = cnt_q + (wide_q ? 6'd4 : 6'd1);
  wire [31:0] sh_next = wide_q ? {sh_q[27:0], io_s} : {sh_q[30:0], io_s[0]};
  wire ind_ok = (sh_next[7:4] == ~sh_next[3:0]);
  wire [5:0] alen = alen32_q ? 6'd32 : 6'd24;
  wire [31:0] boot_start = {boot_reg_q[31:`BOOT_ADDR_LSB], 4'h0};
  wire [1:0] boot_sel = boot_reg_q[`BOOT_DLY_LSB+1:`BOOT_DLY_LSB];

  // fetch side of the two-entry buffer
  wire fetching = (st_q == ST_DUMMY) || (st_q == ST_DATA) ||
    (st_q == ST_BOOT);
  wire buf_in_ready;
  wire buf_out_valid;
  wire [7:0] buf_out_data;
  wire [1:0] ridx = faddr_q[1:0];
  wire [7:0] reg_byte = boot_reg_q[8*(3-ridx) +: 8];
  wire [7:0] fetch_byte = rd_reg_q ? reg_byte : mem[faddr_q[AW-1:0]];
  wire push = fetching && buf_in_ready;
  wire pop = fall && (st_q == ST_DATA) && (ocnt_q == 3'd0);
  wire wrap_here = wrap_on_q && (cmd_q == `OP_QUAD_READ) &&
    !boot_frame_q && !rd_reg_q;
  wire [5:0] wmask = (6'd8 << wrap_depth_q) - 6'd1;
  wire [31:0] finc = faddr_q + 32'd1;
  // wrap groups are at most 64 bytes, so they never leave the page
  wire [31:0] fnext = wrap_here ?
    {faddr_q[31:6], (faddr_q[5:0] & ~wmask) | (finc[5:0] & wmask)} :
    finc;

  byte_buf2 #(.W(8)) u_buf (
    .clk(clk),
    .nrst(nrst),
    .flush(cs_fall || cs_rise),
    .in_valid(fetching),
    .in_ready(buf_in_ready),
    .in_data(fetch_byte),
    .out_valid(buf_out_valid),
    .out_ready(pop),
    .out_data(buf_out_data)
  );

  always @(posedge clk)
  begin
    if (mem_we)
      mem[mem_waddr] <= mem_wdata;
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_d_q <= 1'b0;
      cs_d_q <= 1'b1;
    end
    else
    begin
      sclk_d_q <= sclk_s;
      cs_d_q <= cs_s;
    end
  end

  // boot register survives pin resets; power-on and the erase command restore its default
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      boot_reg_q <= `BOOT_REG_RESET;
    else if (rise && st_q == ST_REGW && nb == 6'd32)
      boot_reg_q <= sh_next;
    else if (cs_rise && erase_pend_q)
      boot_reg_q <= `BOOT_REG_RESET;
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= ST_IDLE;
      wide_q <= 1'b0;
      cnt_q <= 6'd0;
      sh_q <= 32'h0;
      cmd_q <= 8'h0;
      alen32_q <= 1'b0;
      dly_q <= 5'd0;
      wrap_on_q <= 1'b0;
      wrap_depth_q <= 2'd0;
      enhance_q <= 1'b0;
      enh_pend_q <= 1'b0;
      mode_seen_q <= 1'b0;
      erase_pend_q <= 1'b0;
      reset_pend_q <= 1'b0;
      rd_reg_q <= 1'b0;
      boot_frame_q <= 1'b0;
      boot_armed_q <= 1'b0;
      rearm_q <= 1'b1;
      faddr_q <= 32'h0;
    end
    else if (!rst_pin_s || (cs_rise && reset_pend_q))
    begin
      st_q <= ST_IDLE;
      wrap_on_q <= 1'b0;
      enhance_q <= 1'b0;
      mode_seen_q <= 1'b0;
      erase_pend_q <= 1'b0;
      reset_pend_q <= 1'b0;
      boot_frame_q <= 1'b0;
      rearm_q <= 1'b1;
    end
    else
    begin
      if (rearm_q)
      begin
        boot_armed_q <= ~boot_reg_q[`BOOT_EN_N_BIT];
        rearm_q <= 1'b0;
      end
      if (push)
        faddr_q <= fnext;
      if (cs_rise)
      begin
        st_q <= ST_IDLE;
        if (mode_seen_q)
          enhance_q <= enh_pend_q;
        mode_seen_q <= 1'b0;
        erase_pend_q <= 1'b0;
        if (boot_frame_q)
          boot_armed_q <= 1'b0;
        boot_frame_q <= 1'b0;
      end
      else if (cs_fall)
      begin
        cnt_q <= 6'd0;
        rd_reg_q <= 1'b0;
        if (boot_armed_q)
        begin
          st_q <= ST_BOOT;
          boot_frame_q <= 1'b1;
          dly_q <= boot_delay(boot_sel);
          faddr_q <= boot_start;
          wide_q <= quad_enable_bit;
        end
        else if (enhance_q)
        begin
          st_q <= ST_ADDR;
          wide_q <= 1'b1;
        end
        else
        begin
          st_q <= ST_CMD;
          wide_q <= quad_command_mode;
        end
      end
      else if (rise)
      begin
        sh_q <= sh_next;
        cnt_q <= nb;
        case (st_q)
          ST_CMD:
            if (nb == 6'd8)
            begin
              cnt_q <= 6'd0;
              cmd_q <= sh_next[7:0];
              st_q <= ST_SKIP; // all-ones, unknown, erase and reset-modes opcodes
              case (sh_next[7:0])
                `OP_QUAD_READ, `OP_QUAD_READ_4B:
                begin
                  st_q <= ST_ADDR;
                  wide_q <= 1'b1;
                  alen32_q <= addr4_mode ||
                    (sh_next[7:0] == `OP_QUAD_READ_4B);
                end
                `OP_BURST_SET:
                  st_q <= ST_WRAP;
                `OP_BOOT_REG_WRITE:
                  st_q <= ST_REGW;
                `OP_BOOT_REG_READ:
                begin
                  st_q <= ST_DATA;
                  rd_reg_q <= 1'b1;
                  faddr_q <= 32'h0;
                end
                `OP_BOOT_REG_ERASE:
                  erase_pend_q <= 1'b1;
                `OP_RESET_MODES:
                  reset_pend_q <= 1'b1;
                default:
                  st_q <= ST_SKIP;
              endcase
            end
          ST_ADDR:
            if (nb == alen)
            begin
              cnt_q <= 6'd0;
              faddr_q <= alen32_q ? sh_next : {8'h00, sh_next[23:0]};
              st_q <= ST_MODE;
            end
          ST_MODE:
            if (nb == 6'd8)
            begin
              cnt_q <= 6'd0;
              enh_pend_q <= ind_ok;
              mode_seen_q <= 1'b1;
              dly_q <= dummy_cycles({dummy_cfg_high, dummy_cfg_low});
              st_q <= ST_DUMMY;
            end
          ST_DUMMY, ST_BOOT:
          begin
            dly_q <= dly_q - 5'd1;
            if (dly_q == 5'd1)
              st_q <= ST_DATA;
          end
          ST_WRAP:
            if (nb == 6'd8)
            begin
              st_q <= ST_SKIP;
              wrap_on_q <= (sh_next[7:4] == `WRAP_ON_NIBBLE);
              wrap_depth_q <= sh_next[1:0];
            end
          ST_REGW:
            if (nb == 6'd32)
              st_q <= ST_SKIP;
          default:
            cnt_q <= 6'd0;
        endcase
      end
    end
  end

  // output shifter: new bits go out on each sclk falling edge
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      io_out_q <= 4'h0;
      io_oe_q <= 4'h0;
      ocnt_q <= 3'd0;
      obyte_q <= 8'h0;
    end
    else if (cs_s || st_q != ST_DATA)
    begin
      io_oe_q <= 4'h0;
      ocnt_q <= 3'd0;
    end
    else if (fall)
    begin
      if (ocnt_q == 3'd0)
      begin
        // an empty buffer holds the line rather than sending stale data
        if (buf_out_valid)
        begin
          obyte_q <= buf_out_data;
          if (wide_q)
          begin
            io_out_q <= buf_out_data[7:4];
            io_oe_q <= 4'hf;
            ocnt_q <= 3'd1;
          end
          else
          begin
            io_out_q <= {2'b00, buf_out_data[7], 1'b0};
            io_oe_q <= 4'b0010;
            ocnt_q <= 3'd7;
          end
        end
      end
      else
      begin
        ocnt_q <= ocnt_q - 3'd1;
        if (wide_q)
          io_out_q <= obyte_q[3:0];
        else
          io_out_q <= {2'b00, obyte_q[ocnt_q - 3'd1], 1'b0};
      end
    end
  end
endmodule

/* flash_rd_props.sv */
/*
 * Port assertions for the flash read sequencer.
 * Assumes bind to flash_rd_seq; single clock domain, nrst async low.
 */
`timescale 1ns/1ns
module flash_rd_props (
  input wire clk,
  input wire nrst,
  input wire rst_pin_n,
  input wire cs_n,
  input wire sclk,
  input wire [3:0] io_out_q,
  input wire [3:0] io_oe_q,
  input wire wrap_on_q,
  input wire enhance_q,
  input wire boot_armed_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_nrst_quiet: assert property (
    $rose(nrst) |-> io_oe_q == 4'h0 && !wrap_on_q && !enhance_q)
    else $error("mode or drive active after reset");
  a_pin_rst_clears: assert property (
    !rst_pin_n [*5] |-> !wrap_on_q && !enhance_q)
    else $error("hardware reset left a mode on");
  a_enh_at_cs: assert property (
    $rose(enhance_q) |-> cs_n && $past(cs_n, 2))
    else $error("enhance entered inside a frame");
  a_boot_disarm: assert property (
    $fell(boot_armed_q) |-> cs_n)
    else $error("boot disarmed before chip select rise");
  a_boot_arm_idle: assert property (
    $rose(boot_armed_q) |-> cs_n && !enhance_q)
    else $error("boot armed inside a frame");
  a_armed_no_enh: assert property (
    boot_armed_q |-> !enhance_q)
    else $error("boot and enhance both active");
  a_oe_in_frame: assert property (
    io_oe_q != 4'h0 |-> !$past(cs_n, 8) || !cs_n)
    else $error("driving io without chip select");
  a_oe_lines: assert property (
    io_oe_q == 4'h0 || io_oe_q == 4'h2 || io_oe_q == 4'hf)
    else $error("illegal io drive pattern");
  a_out_stands: assert property (
    (!cs_n && sclk) [*5] |-> $stable(io_out_q))
    else $error("io changed while serial clock high");
endmodule

bind flash_rd_seq flash_rd_props i_props (
  .clk(clk), .nrst(nrst), .rst_pin_n(rst_pin_n), .cs_n(cs_n),
  .sclk(sclk), .io_out_q(io_out_q), .io_oe_q(io_oe_q),
  .wrap_on_q(wrap_on_q), .enhance_q(enhance_q),
  .boot_armed_q(boot_armed_q));

/* flash_host.sv */
/*
 * Host controller model: chip select, serial clock (48 ns) and io lines.
 * Assumes clk at 4 ns; a half serial period is 6 clk.
 */
`timescale 1ns/1ns
module flash_host (
  input wire clk,
  input wire [3:0] io_out_q,
  input wire [3:0] io_oe_q,
  output wire [3:0] io_in,
  output reg cs_n,
  output reg sclk
);
  reg [3:0] ho;
  reg [3:0] hoe;
  reg tgl;
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    ho = 4'h0;
    hoe = 4'h0;
    tgl = 1'b0;
  end
  // released lines toggle so a stale level never passes for data
  always @(posedge clk)
    tgl <= ~tgl;
  assign io_in = (io_oe_q & io_out_q) | (~io_oe_q & hoe & ho)
    | (~io_oe_q & ~hoe & {4{tgl}});
  task half;
    repeat (6) @(posedge clk);
  endtask
  task open_frame;
  begin
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
  end
  endtask
  task close_frame;
  begin
    hoe <= 4'h0;
    cs_n <= 1'b1;
    repeat (8) @(posedge clk);
  end
  endtask
  // w lines, n clocks msb first; drv low releases lines and listens
  task xfer(input integer w, input integer n, input [31:0] v,
    input drv, output [31:0] r);
    integer i;
  begin
    r = 32'h0;
    for (i = n - 1; i >= 0; i = i - 1)
    begin
      hoe <= !drv ? 4'h0 : (w == 4 ? 4'hf : 4'h1);
      ho <= w == 4 ? v[4*i +: 4] : {3'b000, v[i]};
      half;
      sclk <= 1'b1;
      r = w == 4 ? {r[27:0], io_in} : {r[30:0], io_in[1]};
      half;
      sclk <= 1'b0;
    end
  end
  endtask
endmodule

/* tb.sv */
/*
 * Self-checking bench: boot register, burst wrap, enhance mode, fast boot.
 * Assumes flash_host and flash_rd_props are compiled before it.
 */
`timescale 1ns/1ns
`include "flash_rd_defines.vh"
module tb;
  reg clk;
  reg nrst;
  reg rst_pin_n;
  reg [1:0] dcfg;
  reg mem_we;
  reg [9:0] mem_waddr;
  reg [7:0] mem_wdata;
  reg [31:0] r;
  reg [9:0] sz;
  reg [31:0] inds;
  reg qe;
  reg qcm;
  reg a4;
  reg [7:0] rop;
  wire cs_n, sclk, wrap_on_q, enhance_q, boot_armed_q;
  wire [3:0] io_in, io_out_q, io_oe_q;
  integer error_cnt, checks_done, cyc, i, f;
  flash_rd_seq #(.AW(10)) i_dut (.clk(clk), .nrst(nrst),
    .rst_pin_n(rst_pin_n), .cs_n(cs_n), .sclk(sclk), .io_in(io_in),
    .io_out_q(io_out_q), .io_oe_q(io_oe_q), .quad_enable_bit(qe),
    .quad_command_mode(qcm), .addr4_mode(a4),
    .dummy_cfg_low(dcfg[0]), .dummy_cfg_high(dcfg[1]), .mem_we(mem_we),
    .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .wrap_on_q(wrap_on_q),
    .enhance_q(enhance_q), .boot_armed_q(boot_armed_q));
  flash_host i_host (.clk(clk), .io_out_q(io_out_q), .io_oe_q(io_oe_q),
    .io_in(io_in), .cs_n(cs_n), .sclk(sclk));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task chk(input [31:0] got, input [31:0] exp);
  begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task summarize;
  begin
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  function [7:0] pat(input [9:0] a);
    pat = a[7:0] ^ 8'h3c;
  endfunction
  task cmd(input [7:0] op);
    i_host.xfer(qcm ? 4 : 1, qcm ? 2 : 8, {24'h0, op}, 1'b1, r);
  endtask
  task bset(input [7:0] v);
  begin
    i_host.open_frame;
    cmd(`OP_BURST_SET);
    i_host.xfer(1, 8, {24'h0, v}, 1'b1, r);
    i_host.close_frame;
  end
  endtask
  // opcode is skipped while the device sits in enhance mode
  task qread(input op_on, input [23:0] a, input [7:0] ind,
    input [1:0] c);
  begin
    dcfg <= c;
    i_host.open_frame;
    if (op_on)
      cmd(rop);
    i_host.xfer(4, (a4 || rop == `OP_QUAD_READ_4B) ? 8 : 6, {8'h0, a},
      1'b1, r);
    i_host.xfer(4, 2, {24'h0, ind}, 1'b1, r);
    i_host.xfer(4, 4 + 2 * c, 32'h0, 1'b0, r);
  end
  endtask
  task rdb(input [9:0] a);
  begin
    i_host.xfer(4, 2, 32'h0, 1'b0, r);
    chk(r, {24'h0, pat(a)});
  end
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      error_cnt = error_cnt + 1;
      summarize;
    end
  end
  initial
  begin
    error_cnt = 0;
    checks_done = 0;
    cyc = 0;
    nrst = 1'b0;
    rst_pin_n = 1'b1;
    dcfg = 2'b00;
    mem_we = 1'b0;
    mem_waddr = 10'h0;
    mem_wdata = 8'h0;
    inds = 32'h0ff05aa5;
    qe = 1'b0;
    qcm = 1'b0;
    a4 = 1'b0;
    rop = `OP_QUAD_READ;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 1024; i = i + 1)
    begin
      mem_we <= 1'b1;
      mem_waddr <= i[9:0];
      mem_wdata <= pat(i[9:0]);
      @(posedge clk);
    end
    mem_we <= 1'b0;
    repeat (4) @(posedge clk);
    chk({wrap_on_q, enhance_q, boot_armed_q}, 3'b000);
    $display("test reset state done");
    // start 0x40, delay code 00, enable low
    i_host.open_frame;
    cmd(`OP_BOOT_REG_WRITE);
    i_host.xfer(1, 32, 32'h00000040, 1'b1, r);
    i_host.close_frame;
    i_host.open_frame;
    cmd(`OP_BOOT_REG_READ);
    i_host.xfer(1, 32, 32'h0, 1'b0, r);
    i_host.close_frame;
    chk(r, 32'h00000040);
    chk(boot_armed_q, 1'b0);
    $display("test boot register done");
    for (f = 0; f < 4; f = f + 1)
    begin
      sz = 10'd8 << f;
      bset(f[7:0]);
      chk(wrap_on_q, 1'b1);
      qread(1'b1, {14'h0, sz - 10'd2}, 8'h00, 2'b00);
      rdb(sz - 10'd2);
      rdb(sz - 10'd1);
      rdb(10'h000);
      i_host.close_frame;
      chk(enhance_q, 1'b0);
    end
    $display("test burst wrap done");
    for (f = 0; f < 4; f = f + 1)
    begin
      sz = 10'h080 + 4 * f;
      qread(f == 0, {14'h0, sz}, inds[8*f +: 8], f[1:0]);
      rdb(sz);
      rdb(sz + 10'd1);
      i_host.close_frame;
      chk(enhance_q, 1'b1);
    end
    i_host.open_frame;
    i_host.xfer(4, 8, 32'hffffffff, 1'b1, r);
    i_host.close_frame;
    chk(enhance_q, 1'b0);
    qread(1'b1, 24'h000080, 8'ha5, 2'b00);
    rdb(10'h080);
    i_host.close_frame;
    chk(enhance_q, 1'b1);
    // one-line reset: io3..1 float, so the indicator can never complement
    i_host.open_frame;
    i_host.xfer(1, 8, 32'h000000ff, 1'b1, r);
    i_host.close_frame;
    chk(enhance_q, 1'b0);
    rop = `OP_QUAD_READ_4B;
    qread(1'b1, 24'h000090, 8'h5a, 2'b00);
    rdb(10'h090);
    i_host.close_frame;
    chk(enhance_q, 1'b1);
    i_host.open_frame;
    i_host.xfer(4, 8, 32'hffffffff, 1'b1, r);
    i_host.xfer(4, 2, 32'h000000ff, 1'b1, r);
    i_host.close_frame;
    chk(enhance_q, 1'b0);
    rop = `OP_QUAD_READ;
    qcm <= 1'b1;
    @(posedge clk);
    qread(1'b1, 24'h0000fe, 8'h00, 2'b00);
    rdb(10'h0fe);
    rdb(10'h0ff);
    rdb(10'h0c0);
    i_host.close_frame;
    chk(enhance_q, 1'b0);
    qcm <= 1'b0;
    a4 <= 1'b1;
    @(posedge clk);
    qread(1'b1, 24'h0000a0, 8'h0f, 2'b00);
    rdb(10'h0a0);
    i_host.close_frame;
    chk(enhance_q, 1'b1);
    $display("test enhance mode done");
    rst_pin_n <= 1'b0;
    a4 <= 1'b0;
    repeat (8) @(posedge clk);
    chk({wrap_on_q, enhance_q}, 2'b00);
    rst_pin_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk(boot_armed_q, 1'b1);
    i_host.open_frame;
    i_host.xfer(1, 7, 32'h0, 1'b0, r);
    i_host.xfer(1, 8, 32'h0, 1'b0, r);
    chk(r, {24'h0, pat(10'h040)});
    i_host.xfer(1, 8, 32'h0, 1'b0, r);
    chk(r, {24'h0, pat(10'h041)});
    i_host.close_frame;
    chk(boot_armed_q, 1'b0);
    bset(8'h00);
    chk(wrap_on_q, 1'b1);
    bset(8'h10);
    chk(wrap_on_q, 1'b0);
    // start 0x150, delay code 11, enable low; reset command re-arms
    i_host.open_frame;
    cmd(`OP_BOOT_REG_WRITE);
    i_host.xfer(1, 32, 32'h00000156, 1'b1, r);
    i_host.close_frame;
    bset(8'h02);
    chk(wrap_on_q, 1'b1);
    qe <= 1'b1;
    i_host.open_frame;
    cmd(`OP_RESET_MODES);
    i_host.close_frame;
    chk({wrap_on_q, boot_armed_q}, 2'b01);
    i_host.open_frame;
    i_host.xfer(4, 13, 32'h0, 1'b0, r);
    rdb(10'h150);
    i_host.close_frame;
    chk(boot_armed_q, 1'b0);
    i_host.open_frame;
    cmd(`OP_BOOT_REG_ERASE);
    i_host.close_frame;
    i_host.open_frame;
    cmd(`OP_BOOT_REG_READ);
    i_host.xfer(1, 32, 32'h0, 1'b0, r);
    i_host.close_frame;
    chk(r, `BOOT_REG_RESET);
    $display("test fast boot done");
    summarize;
  end
endmodule
